// [ldc_pkg.sv]
// constants for the dc dimming, configuration and string mask registers
// assumes byte wide registers reached by smbus write byte and read byte cycles
package ldc_pkg;
    localparam int DATA_W = 8;
    localparam int LANE_COUNT = 8;
    localparam int SYNC_STAGES = 3;

    // ----------------------------------------
    // register offsets (command codes)
    // ----------------------------------------
    localparam logic [7:0] OFF_DC_LEVEL = 8'h07;
    localparam logic [7:0] OFF_CONFIG = 8'h08;
    localparam logic [7:0] OFF_LANE_MASK = 8'h09;

    // ----------------------------------------
    // values after reset and for unmapped reads
    // ----------------------------------------
    localparam logic [7:0] DC_LEVEL_RESET = 8'hff;
    localparam logic [7:0] CONFIG_RESET = 8'hff;
    localparam logic [7:0] LANE_MASK_RESET = 8'hff;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ----------------------------------------
    // configuration field positions
    // ----------------------------------------
    localparam int SHORT_SEL_LSB = 0;
    localparam int SHORT_SEL_W = 2;
    localparam int FREQ_SEL_BIT = 2;

    // ----------------------------------------
    // bus engine counts
    // ----------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0011,
        ST_CMD = 4'b0010,
        ST_CMD_ACK = 4'b0110,
        ST_WDATA = 4'b0111,
        ST_WDATA_ACK = 4'b0101,
        ST_RDATA = 4'b0100,
        ST_RDATA_ACK = 4'b1100
    } ldc_state_t;
endpackage

// [ldc_lane_if.sv]
// per-string signals between the register engine and the string guard
// assumes both ends run on mclk
`timescale 1ns/10ps
interface ldc_lane_if;
    logic [ldc_pkg::LANE_COUNT-1:0] lane_enable_bits;
    logic [ldc_pkg::LANE_COUNT-1:0] lane_on;

    modport regs (output lane_enable_bits, input lane_on);
    modport guard (input lane_enable_bits, output lane_on);
endinterface

// [ldc_lane_guard.sv]
// per-string fault latch and current sink enable
// assumes lane_fault pins are asynchronous to mclk
`timescale 1ns/10ps
module ldc_lane_guard (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ldc_pkg::LANE_COUNT-1:0] lane_fault,
    ldc_lane_if.guard lif
);
    import ldc_pkg::*;

    // ----------------------------------------
    // one guard per string
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < LANE_COUNT; i++) begin : g_lane
            logic f1, f2, f3, fault_lvl, latched;

            always_ff @(posedge mclk) begin
                if (rst) begin
                    f1 <= 1'b0;
                    f2 <= 1'b0;
                    f3 <= 1'b0;
                    fault_lvl <= 1'b0;
                end else begin
                    f1 <= lane_fault[i];
                    f2 <= f1;
                    f3 <= f2;
                    if (f2 == f3) begin
                        fault_lvl <= f3;
                    end
                end
            end

            // fault holds until the string is disabled
            always_ff @(posedge mclk) begin
                if (rst) begin
                    latched <= 1'b0;
                end else if (!lif.lane_enable_bits[i]) begin
                    latched <= 1'b0;
                end else if (fault_lvl) begin
                    latched <= 1'b1;
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    lif.lane_on[i] <= LANE_MASK_RESET[i];
                end else begin
                    lif.lane_on[i] <= lif.lane_enable_bits[i] & ~latched & ~fault_lvl;
                end
            end
        end
    endgenerate
endmodule

// [ldc_dim_regs.sv]
// smbus register slave for dc dimming level, configuration and string mask
// assumes an external open-drain sda wire resolved from sda_oe, scl input only
`timescale 1ns/10ps
module ldc_dim_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2c, // arbitrary value
    parameter logic [1:0] SC_CODE_OFF = 2'b00,
    parameter logic [1:0] SC_CODE_LOW = 2'b01
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [ldc_pkg::LANE_COUNT-1:0] lane_fault,
    output logic [ldc_pkg::DATA_W-1:0] dc_level,
    output logic short_detect_en,
    output logic short_thresh_high,
    output logic boost_freq_high,
    output logic [ldc_pkg::LANE_COUNT-1:0] lane_on
);
    import ldc_pkg::*;

    logic [1:0] sy1, sy2, sy3, filt, filt_d;
    logic scl_rise, scl_fall, sda_hi, bus_start, bus_stop;
    ldc_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg, ptr, wdata, rd_data, config_reg;
    logic is_read, wr_stb;
    logic [1:0] short_threshold_sel;
    logic switch_freq_sel;

    ldc_lane_if lif ();

    // ----------------------------------------
    // pin synchronisers, bit 0 scl, bit 1 sda
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            sy1 <= 2'h3;
            sy2 <= 2'h3;
            sy3 <= 2'h3;
            filt <= 2'h3;
            filt_d <= 2'h3;
        end else begin
            sy1 <= {sda_in, scl};
            sy2 <= sy1;
            sy3 <= sy2;
            filt <= (~(sy2 ^ sy3) & sy3) | ((sy2 ^ sy3) & filt);
            filt_d <= filt;
        end
    end

    assign scl_rise = filt[0] & ~filt_d[0];
    assign scl_fall = ~filt[0] & filt_d[0];
    assign sda_hi = filt[1];
    assign bus_start = filt[0] & filt_d[0] & filt_d[1] & ~filt[1];
    assign bus_stop = filt[0] & filt_d[0] & ~filt_d[1] & filt[1];

    // ----------------------------------------
    // byte engine
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            wdata <= 8'h00;
            is_read <= 1'b0;
            wr_stb <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            if (bus_start) begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (bus_stop) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    ST_ADDR, ST_CMD, ST_WDATA: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_hi};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                            bit_cnt <= 4'h0;
                            if (state == ST_ADDR) begin
                                if (shreg[7:1] == DEV_ADDR) begin
                                    is_read <= shreg[0];
                                    sda_oe <= 1'b1;
                                    state <= ST_ADDR_ACK;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else if (state == ST_CMD) begin
                                ptr <= shreg;
                                sda_oe <= 1'b1;
                                state <= ST_CMD_ACK;
                            end else begin
                                wdata <= shreg;
                                wr_stb <= 1'b1;
                                sda_oe <= 1'b1;
                                state <= ST_WDATA_ACK;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (is_read) begin
                                shreg <= rd_data;
                                sda_oe <= ~rd_data[7];
                                state <= ST_RDATA;
                            end else begin
                                sda_oe <= 1'b0;
                                state <= ST_CMD;
                            end
                        end
                    end
                    ST_CMD_ACK, ST_WDATA_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state <= ST_WDATA;
                        end
                    end
                    ST_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == BITS_PER_BYTE) begin
                                bit_cnt <= 4'h0;
                                sda_oe <= 1'b0;
                                state <= ST_RDATA_ACK;
                            end else begin
                                shreg <= {shreg[6:0], 1'b0};
                                sda_oe <= ~shreg[6];
                            end
                        end
                    end
                    ST_RDATA_ACK: begin
                        if (scl_rise) begin
                            state <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // sda is only ever pulled low
    always_ff @(posedge mclk) begin
        sda_out <= 1'b0;
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            dc_level <= DC_LEVEL_RESET;
            config_reg <= CONFIG_RESET;
            lif.lane_enable_bits <= LANE_MASK_RESET;
        end else if (wr_stb) begin
            if (ptr == OFF_DC_LEVEL) begin
                dc_level <= wdata;
            end else if (ptr == OFF_CONFIG) begin
                config_reg <= wdata;
            end else if (ptr == OFF_LANE_MASK) begin
                lif.lane_enable_bits <= wdata;
            end
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        if (ptr == OFF_DC_LEVEL) begin
            rd_data = dc_level;
        end else if (ptr == OFF_CONFIG) begin
            rd_data = config_reg;
        end else if (ptr == OFF_LANE_MASK) begin
            rd_data = lif.lane_on;
        end else begin
            rd_data = READ_UNMAPPED;
        end
    end

    // ----------------------------------------
    // configuration decode to analog controls
    // ----------------------------------------
    assign short_threshold_sel = config_reg[SHORT_SEL_LSB +: SHORT_SEL_W];
    assign switch_freq_sel = config_reg[FREQ_SEL_BIT];

    always_ff @(posedge mclk) begin
        if (rst) begin
            short_detect_en <= CONFIG_RESET[SHORT_SEL_LSB +: SHORT_SEL_W] != SC_CODE_OFF;
            short_thresh_high <= CONFIG_RESET[SHORT_SEL_LSB +: SHORT_SEL_W] != SC_CODE_OFF
                && CONFIG_RESET[SHORT_SEL_LSB +: SHORT_SEL_W] != SC_CODE_LOW;
            boost_freq_high <= CONFIG_RESET[FREQ_SEL_BIT];
        end else begin
            short_detect_en <= short_threshold_sel != SC_CODE_OFF;
            short_thresh_high <= short_threshold_sel != SC_CODE_OFF
                && short_threshold_sel != SC_CODE_LOW;
            boost_freq_high <= switch_freq_sel;
        end
    end

    ldc_lane_guard u_guard (
        .mclk(mclk),
        .rst(rst),
        .lane_fault(lane_fault),
        .lif(lif)
    );

    assign lane_on = lif.lane_on;
endmodule

// [ldc_dim_regs_chk.sv]
// concurrent checks on the ports of the dimming register block
// assumes one clock mclk and a synchronous active high rst
`timescale 1ns/10ps
module ldc_dim_regs_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [ldc_pkg::LANE_COUNT-1:0] lane_fault,
    input wire logic [ldc_pkg::DATA_W-1:0] dc_level,
    input wire logic short_detect_en,
    input wire logic short_thresh_high,
    input wire logic boost_freq_high,
    input wire logic [ldc_pkg::LANE_COUNT-1:0] lane_on
);
    import ldc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    a_reset_values: assert property (rst |=> dc_level == 8'hff && lane_on == 8'hff
        && short_detect_en && short_thresh_high && boost_freq_high && !sda_oe)
        else $error("outputs not at reset values");
    a_dc_on_ack: assert property (disable iff (rst) $changed(dc_level) |-> sda_oe)
        else $error("dc level moved outside a write");
    a_cfg_on_ack: assert property (disable iff (rst)
        $changed({short_detect_en, short_thresh_high, boost_freq_high}) |-> $past(sda_oe))
        else $error("config outputs moved outside a write");
    a_lane_rise_write: assert property (disable iff (rst)
        (lane_on & ~$past(lane_on)) != 8'h00 |-> $past(sda_oe) || $past(sda_oe, 2))
        else $error("string came on without a mask write");
    a_fault_kills_lane: assert property (disable iff (rst)
        (lane_fault & $past(lane_fault, 6) & lane_on) == 8'h00)
        else $error("faulted string still on");
    a_oe_scl_low: assert property (disable iff (rst) $rose(sda_oe) |-> !scl)
        else $error("data line taken while clock high");
    a_oe_release: assert property (disable iff (rst) $rose(sda_oe) |-> ##[1:250] !sda_oe)
        else $error("data line held too long");
    a_out_low: assert property (disable iff (rst) sda_oe |-> !sda_out)
        else $error("data line driven high");
    cover property (disable iff (rst) $changed(dc_level));
    cover property (disable iff (rst) $fell(lane_on[3]));
    cover property (disable iff (rst) $rose(sda_oe) ##1 sda_oe);
endmodule
bind ldc_dim_regs ldc_dim_regs_chk i_ldc_dim_regs_chk (.mclk(mclk), .rst(rst), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .lane_fault(lane_fault),
    .dc_level(dc_level), .short_detect_en(short_detect_en),
    .short_thresh_high(short_thresh_high), .boost_freq_high(boost_freq_high),
    .lane_on(lane_on));

// [ldc_smb_host.sv]
// smbus host model issuing write byte and read byte cycles
// assumes an open-drain data wire with pull-up resolved by the bench
`timescale 1ns/10ps
module ldc_smb_host (
    input wire logic mclk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    localparam int HALF = 8;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hold();
        repeat (HALF) @(posedge mclk);
    endtask
    // also serves as repeated start
    task automatic start();
        sda_low <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda_low <= 1'b1;
        hold();
        scl <= 1'b0;
    endtask
    task automatic bit_io(input logic b, output logic r);
        hold();
        sda_low <= ~b;
        hold();
        scl <= 1'b1;
        hold();
        r = sda;
        scl <= 1'b0;
    endtask
    // ack slot always released; ak low means acknowledged
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'b1, ak);
    endtask
    task automatic xfer(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] d,
        input logic rnw, output logic [7:0] q, output logic ak);
        logic [7:0] x;
        logic k;
        start();
        byte_io({a, 1'b0}, x, ak);
        byte_io(cmd, x, k);
        if (rnw) begin
            start();
            byte_io({a, 1'b1}, x, k);
            byte_io(8'hff, q, k);
        end else begin
            byte_io(d, q, k);
        end
        hold();
        sda_low <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_low <= 1'b0;
        hold();
    endtask
endmodule

// [test_ldc_dim_regs.sv]
// self-checking bench for the dimming register block
// assumes the smbus host model drives the bus and a pull-up on data
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    $display("wrong value %s exp %h got %h", nm, ex, got); n_mismatch++; end end
module test_ldc_dim_regs;
    import ldc_pkg::*;
    localparam logic [6:0] DEV = 7'h2c; // arbitrary value
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] lane_fault = 8'h00;
    logic sda_out, sda_oe, short_detect_en, short_thresh_high, boost_freq_high;
    logic [7:0] dc_level, lane_on, cf, q;
    logic ak;
    wire scl, host_low;
    wire sda = ~((sda_oe & ~sda_out) | host_low);
    wire [2:0] cfg_out = {short_detect_en, short_thresh_high, boost_freq_high};
    int n_mismatch = 0;
    int compares = 0;
    ldc_smb_host i_ldc_smb_host (.mclk(mclk), .scl(scl), .sda_low(host_low), .sda(sda));
    ldc_dim_regs #(.DEV_ADDR(DEV)) i_ldc_dim_regs (.mclk(mclk), .rst(rst), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .lane_fault(lane_fault),
        .dc_level(dc_level), .short_detect_en(short_detect_en),
        .short_thresh_high(short_thresh_high), .boost_freq_high(boost_freq_high),
        .lane_on(lane_on));
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic finish_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        i_ldc_smb_host.xfer(DEV, off, d, 1'b0, q, ak);
        `CHK("write ack", 1'b0, ak)
    endtask
    task automatic rd_chk(input logic [7:0] off, input logic [7:0] e);
        i_ldc_smb_host.xfer(DEV, off, 8'h00, 1'b1, q, ak);
        `CHK("read ack", 1'b0, ak)
        `CHK("read data", e, q)
    endtask
    task automatic do_reset();
        @(posedge mclk) rst <= 1'b1;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        `CHK("dc reset", 8'hff, dc_level)
        `CHK("cfg reset", 3'b111, cfg_out)
        `CHK("lane reset", 8'hff, lane_on)
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        finish_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        do_reset();
        rd_chk(OFF_DC_LEVEL, 8'hff);
        rd_chk(OFF_CONFIG, 8'hff);
        rd_chk(OFF_LANE_MASK, 8'hff);
        wr(OFF_DC_LEVEL, 8'h40);
        `CHK("dc level", 8'h40, dc_level)
        `CHK("cfg kept", 3'b111, cfg_out)
        `CHK("lanes kept", 8'hff, lane_on)
        rd_chk(OFF_DC_LEVEL, 8'h40);
        wr(OFF_DC_LEVEL, 8'h00);
        rd_chk(OFF_DC_LEVEL, 8'h00);
        for (int i = 0; i < 8; i++) begin
            cf = 8'ha0 | i[7:0];
            wr(OFF_CONFIG, cf);
            `CHK("detect", cf[1:0] != 2'b00, short_detect_en)
            if (cf[1:0] != 2'b00) `CHK("thresh", cf[1], short_thresh_high)
            `CHK("freq", cf[2], boost_freq_high)
            rd_chk(OFF_CONFIG, cf);
        end
        `CHK("dc kept", 8'h00, dc_level)
        wr(OFF_LANE_MASK, 8'ha5);
        `CHK("lanes", 8'ha5, lane_on)
        rd_chk(OFF_LANE_MASK, 8'ha5);
        wr(OFF_LANE_MASK, 8'hfe);
        lane_fault <= 8'h49;
        repeat (10) @(posedge mclk);
        `CHK("fault off", 8'hb6, lane_on)
        rd_chk(OFF_LANE_MASK, 8'hb6);
        lane_fault <= 8'h00;
        repeat (10) @(posedge mclk);
        `CHK("latched", 8'hb6, lane_on)
        wr(OFF_LANE_MASK, 8'hb7);
        `CHK("others run", 8'hb7, lane_on)
        wr(OFF_LANE_MASK, 8'hff);
        rd_chk(OFF_LANE_MASK, 8'hff);
        wr(8'h0a, 8'h12);
        rd_chk(8'h0a, READ_UNMAPPED);
        i_ldc_smb_host.xfer(7'h2d, OFF_DC_LEVEL, 8'h33, 1'b0, q, ak);
        `CHK("foreign nack", 1'b1, ak)
        `CHK("dc untouched", 8'h00, dc_level)
        do_reset();
        finish_test();
    end
endmodule
